// File: common/rmhs_pkg.sv
package rmhs_pkg;
  // Clock and time bases
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1_000;
  // Startup timing
  localparam int unsigned BOOT_DELAY_US = 100;
  localparam int unsigned BOOT_DELAY_CYC = BOOT_DELAY_US * CYC_PER_US;
  localparam int unsigned CAL_MIN_MS    = 2;
  localparam int unsigned CAL_CYC       = CAL_MIN_MS * CYC_PER_MS;
  localparam int unsigned READY_LOW_MS  = 5;
  localparam int unsigned READY_LOW_CYC = READY_LOW_MS * CYC_PER_MS;
  localparam int unsigned READY_MAX_MS  = 1000;
  localparam int unsigned READY_MAX_CYC = READY_MAX_MS * CYC_PER_MS;
  // Widths
  localparam int unsigned DW     = 8;
  localparam int unsigned RW     = 16;
  localparam int unsigned AW     = 4;
  localparam int unsigned BUF_AW = 4;
  localparam int unsigned CNT_W  = 20;
  localparam int unsigned MS_W   = 16;
  // Register indexes
  localparam logic [AW-1:0] REG_FLAGS    = 4'h0;
  localparam logic [AW-1:0] REG_ACTIVE   = 4'h1;
  localparam logic [AW-1:0] REG_MODE     = 4'h2;
  localparam logic [AW-1:0] REG_LISTEN   = 4'h3;
  localparam logic [AW-1:0] REG_OWN_ADDR = 4'h4;
  localparam logic [AW-1:0] REG_STATUS   = 4'h5;
  // Flag bit positions
  localparam int unsigned FLG_NO_CFG_PIN    = 0;
  localparam int unsigned FLG_NO_DATA_REQ   = 1;
  localparam int unsigned FLG_NO_BREAK      = 2;
  localparam int unsigned FLG_NO_SLEEP_PINS = 3;
  localparam int unsigned FLG_ANY_CSUM      = 5;
  localparam int unsigned FLG_SNIFFER       = 7;
  localparam int unsigned FLG_USE_CTS       = 8;
  localparam int unsigned FLG_LEDS          = 9;
  // Reset values, masks, broadcast address and mode code
  localparam logic [RW-1:0] FLAGS_WRITABLE = 16'h03AF;
  localparam logic [RW-1:0] FLAGS_RESET    = 16'h0000;
  localparam logic          MODE_RESET     = 1'h0;
  localparam logic [DW-1:0] LISTEN_RESET   = 8'h0A;
  localparam logic [DW-1:0] OWN_ADDR_RESET = 8'h01;
  localparam logic [DW-1:0] BCAST_ADDR     = 8'hFF;
  localparam logic          MODE_TRANSP    = 1'h0;
  // Device states
  typedef enum logic [2:0] {
    ST_HOLD, ST_DELAY, ST_BOOT, ST_SETTLE,
    ST_RUN, ST_TX, ST_SLEEP, ST_LISTEN
  } rmhs_state_t;
endpackage

// File: logic/rmhs_byte_buf.sv
`timescale 1ns/100ps
module rmhs_byte_buf (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      push,
  input  wire logic [rmhs_pkg::DW-1:0]   push_data,
  input  wire logic                      pop,
  input  wire logic                      flush,
  output logic      [rmhs_pkg::DW-1:0]   head,
  output logic      [rmhs_pkg::BUF_AW:0] count,
  output logic                           full,
  output logic                           empty
);
  import rmhs_pkg::*;
  localparam int unsigned DEPTH = 2 ** BUF_AW;

  logic [DW-1:0]     mem_q [DEPTH];
  logic [BUF_AW-1:0] wr_q;
  logic [BUF_AW-1:0] rd_q;
  logic [BUF_AW:0]   cnt_q;
  wire               do_push = push & ~full;
  wire               do_pop  = pop & ~empty;

  // Status and head of line
  assign full  = (cnt_q == (BUF_AW+1)'(DEPTH));
  assign empty = (cnt_q == '0);
  assign head  = mem_q[rd_q];
  assign count = cnt_q;

  // Storage cells, one per slot
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        mem_q[i] <= '0;
      end else if (do_push && wr_q == BUF_AW'(i)) begin
        mem_q[i] <= push_data;
      end
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_q + BUF_AW'(do_push);
      rd_q  <= rd_q + BUF_AW'(do_pop);
      cnt_q <= cnt_q + (BUF_AW+1)'(do_push) - (BUF_AW+1)'(do_pop);
    end
  end
endmodule // rmhs_byte_buf

// File: logic/rmhs_device.sv
// Contract
// - Timed wake listens for the set milliseconds, then sleeps again.
// - Flag 0x0001 makes the mode toggle pin do nothing.
// - Flag 0x0002 disables the send request pin, used only in transparent.
// - Flag 0x0004 suppresses break detection, so no mode toggle.
// - Flag 0x0008 ignores the sleep and radio off pin levels.
// - Flag 0x0020 accepts any checksum byte in command mode.
// - Flag 0x0080 skips address filtering, forwards every packet.
// - Flag 0x0100 uses CTS for UART flow; host must drive it.
// - Flag 0x0200 drives receive and transmit activity outputs.
// - Flags 0x0001 and 0x0004 together freeze the operating mode.
// - After reset RTS high during boot, then low; 5 ms low means ready.
// - Ready within 1000 ms after reset release.
// - RTS rises about 100 us after release, calibrates 2 ms or more.
// - Sleep entry and exit shown on RTS; host waits low plus 100 us. Here exit holds RTS low 5 ms in ST_SETTLE before ready.
// - UART data buffered until trigger, then RTS halts and FIFO loads.
// - Radio send starts at first FIFO byte; rest fed in chunks.
// - Received packet fully read, address checked, then sent on UART.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module rmhs_device #(
  parameter int unsigned BOOT_DELAY_CYCLES = rmhs_pkg::BOOT_DELAY_CYC,
  parameter int unsigned CAL_CYCLES        = rmhs_pkg::CAL_CYC,
  parameter int unsigned READY_CYCLES      = rmhs_pkg::READY_LOW_CYC,
  parameter int unsigned MS_CYCLES         = rmhs_pkg::CYC_PER_MS
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    restart_n,
  input  wire logic [rmhs_pkg::AW-1:0] reg_addr,
  input  wire logic [rmhs_pkg::RW-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [rmhs_pkg::RW-1:0] reg_rdata,
  input  wire logic                    uart_rx_valid,
  input  wire logic [rmhs_pkg::DW-1:0] uart_rx_data,
  input  wire logic                    uart_break,
  output logic                         uart_tx_valid,
  output logic      [rmhs_pkg::DW-1:0] uart_tx_data,
  input  wire logic                    uart_tx_ready,
  input  wire logic                    cts_n,
  output logic                         rts_n,
  input  wire logic                    config_pin_n,
  input  wire logic                    data_req_n,
  input  wire logic                    sleep_pin,
  input  wire logic                    radio_off_pin,
  input  wire logic                    wor_wake,
  input  wire logic                    tx_trigger,
  output logic                         radio_fifo_wr,
  output logic      [rmhs_pkg::DW-1:0] radio_fifo_data,
  input  wire logic                    radio_fifo_ready,
  output logic                         radio_tx_start,
  input  wire logic                    radio_rx_valid,
  input  wire logic [rmhs_pkg::DW-1:0] radio_rx_data,
  input  wire logic                    radio_rx_last,
  output logic                         radio_rx_enable,
  output logic                         op_mode,
  output logic                         checksum_any,
  output logic                         led_rx,
  output logic                         led_tx,
  output logic                         ready
);
  import rmhs_pkg::*;

  function automatic logic reg_hit(input logic [AW-1:0] a,
                                   input logic [AW-1:0] idx);
    reg_hit = (a == idx);
  endfunction

  rmhs_state_t     state_q, state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [MS_W-1:0]  ms_div_q;
  logic [DW-1:0]    listen_cnt_q;
  logic [RW-1:0]    flags_q, act_q;
  logic             mode_set_q, op_mode_q;
  logic [DW-1:0]    listen_q, own_q;
  logic             cfg_prev_q, req_prev_q, first_q;
  logic             rx_first_q, addr_ok_q, rx_drain_q;
  logic             rts_q, ready_q, rx_en_q, csum_q, led_rx_q, led_tx_q;
  logic             fwr_q, fstart_q, utx_valid_q;
  logic [DW-1:0]    fdata_q, utx_data_q;
  logic [RW-1:0]    rdata_q, rd_val;
  logic [DW-1:0]    txb_head, rxb_head;
  logic [BUF_AW:0]  txb_count, rxb_count;
  logic             txb_full, txb_empty, rxb_full, rxb_empty;

  // Pin gating by the active flag word
  wire sleep_eff  = sleep_pin & ~act_q[FLG_NO_SLEEP_PINS];
  wire roff_eff   = radio_off_pin & ~act_q[FLG_NO_SLEEP_PINS];
  wire cfg_fall   = cfg_prev_q & ~config_pin_n;
  wire tog_pin    = cfg_fall & ~act_q[FLG_NO_CFG_PIN];
  wire tog_brk    = uart_break & ~act_q[FLG_NO_BREAK];
  wire mode_tog   = (state_q == ST_RUN) & (tog_pin | tog_brk);
  wire req_fall   = req_prev_q & ~data_req_n;
  wire req_trig   = req_fall & ~act_q[FLG_NO_DATA_REQ]
                    & (op_mode_q == MODE_TRANSP);
  wire cts_ok     = ~act_q[FLG_USE_CTS] | ~cts_n;

  // Transmit path decode
  wire uart_push  = uart_rx_valid & (state_q == ST_RUN);
  wire tx_go      = (state_q == ST_RUN) & ~txb_empty
                    & (tx_trigger | req_trig | txb_full);
  wire fifo_go    = (state_q == ST_TX) & radio_fifo_ready
                    & ~txb_empty;

  // Receive path decode
  wire rx_accept  = radio_rx_valid & rx_en_q & ~rx_drain_q;
  wire addr_match = act_q[FLG_SNIFFER] | (radio_rx_data == own_q)
                    | (radio_rx_data == BCAST_ADDR);
  wire pkt_ok     = rx_first_q ? addr_match : addr_ok_q;
  wire pkt_end    = rx_accept & radio_rx_last;
  wire rx_flush   = pkt_end & ~pkt_ok;
  wire utx_take   = utx_valid_q & uart_tx_ready & cts_ok;
  wire utx_load   = rx_drain_q & ~rxb_empty
                    & (~utx_valid_q | utx_take);

  // Timers
  wire cnt_end_delay = (cnt_q == CNT_W'(BOOT_DELAY_CYCLES - 1));
  wire cnt_end_cal   = (cnt_q == CNT_W'(CAL_CYCLES - 1));
  wire cnt_end_ready = (cnt_q == CNT_W'(READY_CYCLES - 1));
  wire ms_tick       = (ms_div_q == MS_W'(MS_CYCLES - 1));
  wire listen_end    = ms_tick & (listen_cnt_q + 8'h01 >= listen_q);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:   if (restart_n) state_d = ST_DELAY;
      ST_DELAY:  if (cnt_end_delay) state_d = ST_BOOT;
      ST_BOOT:   if (cnt_end_cal) state_d = ST_SETTLE;
      ST_SETTLE: if (cnt_end_ready) state_d = ST_RUN;
      ST_RUN: begin
        if (tx_go) state_d = ST_TX;
        else if (sleep_eff && txb_empty) state_d = ST_SLEEP;
      end
      ST_TX:     if (txb_empty) state_d = ST_RUN;
      ST_SLEEP: begin
        if (!sleep_eff) state_d = ST_SETTLE;
        else if (wor_wake && listen_q != '0) state_d = ST_LISTEN;
      end
      ST_LISTEN: begin
        if (!sleep_eff) state_d = ST_SETTLE;
        else if (listen_end) state_d = ST_SLEEP;
      end
      default:   state_d = ST_HOLD;
    endcase
    if (!restart_n) state_d = ST_HOLD;
  end

  // Output next values
  wire rts_d   = (state_d == ST_BOOT) | (state_d == ST_TX)
                 | (state_d == ST_SLEEP) | (state_d == ST_LISTEN);
  wire ready_d = (state_d == ST_RUN) | (state_d == ST_TX);
  wire rx_en_d = ((state_d == ST_RUN) | (state_d == ST_TX)
                 | (state_d == ST_LISTEN)) & ~roff_eff;

  // State and sequencing timers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q      <= ST_HOLD;
      cnt_q        <= '0;
      ms_div_q     <= '0;
      listen_cnt_q <= '0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
      ms_div_q     <= (state_q != ST_LISTEN || ms_tick) ? '0
                      : ms_div_q + 1'b1;
      listen_cnt_q <= (state_q != ST_LISTEN) ? '0
                      : listen_cnt_q + DW'(ms_tick);
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q    <= FLAGS_RESET;
      mode_set_q <= MODE_RESET;
      listen_q   <= LISTEN_RESET;
      own_q      <= OWN_ADDR_RESET;
    end else if (reg_wr) begin
      if (reg_hit(reg_addr, REG_FLAGS))
        flags_q <= reg_wdata & FLAGS_WRITABLE;
      if (reg_hit(reg_addr, REG_MODE))
        mode_set_q <= reg_wdata[0];
      if (reg_hit(reg_addr, REG_LISTEN))
        listen_q <= reg_wdata[DW-1:0];
      if (reg_hit(reg_addr, REG_OWN_ADDR))
        own_q <= reg_wdata[DW-1:0];
    end
  end

  // Active flags and mode, reloaded only at restart release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_q     <= FLAGS_RESET;
      op_mode_q <= MODE_RESET;
    end else if (state_q == ST_HOLD && restart_n) begin
      act_q     <= flags_q;
      op_mode_q <= mode_set_q;
    end else if (mode_tog) begin
      op_mode_q <= ~op_mode_q;
    end
  end

  // Read mux
  always_comb begin
    rd_val = '0;
    if (reg_hit(reg_addr, REG_FLAGS))
      rd_val = flags_q;
    else if (reg_hit(reg_addr, REG_ACTIVE))
      rd_val = act_q;
    else if (reg_hit(reg_addr, REG_MODE))
      rd_val = {15'h0000, mode_set_q};
    else if (reg_hit(reg_addr, REG_LISTEN))
      rd_val = {8'h00, listen_q};
    else if (reg_hit(reg_addr, REG_OWN_ADDR))
      rd_val = {8'h00, own_q};
    else if (reg_hit(reg_addr, REG_STATUS))
      rd_val = {5'h00, rxb_count[3:0], state_q, rx_drain_q,
                ready_q, op_mode_q, txb_empty};
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata_q <= '0;
    else       rdata_q <= reg_rd ? rd_val : '0;
  end

  // Pin edge history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_prev_q <= 1'b1;
      req_prev_q <= 1'b1;
    end else begin
      cfg_prev_q <= config_pin_n;
      req_prev_q <= data_req_n;
    end
  end

  // UART to radio buffer
  rmhs_byte_buf u_txb (
    .clk       (clk),
    .nrst      (nrst),
    .push      (uart_push),
    .push_data (uart_rx_data),
    .pop       (fifo_go),
    .flush     (state_q == ST_HOLD),
    .head      (txb_head),
    .count     (txb_count),
    .full      (txb_full),
    .empty     (txb_empty)
  );

  // Radio to UART buffer
  rmhs_byte_buf u_rxb (
    .clk       (clk),
    .nrst      (nrst),
    .push      (rx_accept),
    .push_data (radio_rx_data),
    .pop       (utx_load),
    .flush     (rx_flush | (state_q == ST_HOLD)),
    .head      (rxb_head),
    .count     (rxb_count),
    .full      (rxb_full),
    .empty     (rxb_empty)
  );

  // Transceiver FIFO feed, start pulse on first byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fwr_q    <= 1'b0;
      fdata_q  <= '0;
      fstart_q <= 1'b0;
      first_q  <= 1'b0;
    end else begin
      fwr_q    <= fifo_go;
      fdata_q  <= fifo_go ? txb_head : fdata_q;
      fstart_q <= fifo_go & first_q;
      first_q  <= tx_go ? 1'b1 : (fifo_go ? 1'b0 : first_q);
    end
  end

  // Receive packet tracking and UART drain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_first_q  <= 1'b1;
      addr_ok_q   <= 1'b0;
      rx_drain_q  <= 1'b0;
      utx_valid_q <= 1'b0;
      utx_data_q  <= '0;
    end else begin
      if (rx_accept) begin
        rx_first_q <= radio_rx_last;
        addr_ok_q  <= pkt_ok;
      end
      if (pkt_end && pkt_ok)
        rx_drain_q <= 1'b1;
      else if (rx_drain_q && rxb_empty)
        rx_drain_q <= 1'b0;
      if (utx_load) begin
        utx_valid_q <= 1'b1;
        utx_data_q  <= rxb_head;
      end else if (utx_take) begin
        utx_valid_q <= 1'b0;
      end
    end
  end

  // Status pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rts_q    <= 1'b0;
      ready_q  <= 1'b0;
      rx_en_q  <= 1'b0;
      csum_q   <= 1'b0;
      led_rx_q <= 1'b0;
      led_tx_q <= 1'b0;
    end else begin
      rts_q    <= rts_d;
      ready_q  <= ready_d;
      rx_en_q  <= rx_en_d;
      csum_q   <= act_q[FLG_ANY_CSUM];
      led_rx_q <= act_q[FLG_LEDS] & rx_accept;
      led_tx_q <= act_q[FLG_LEDS] & fifo_go;
    end
  end

  assign reg_rdata       = rdata_q;
  assign uart_tx_valid   = utx_valid_q;
  assign uart_tx_data    = utx_data_q;
  assign rts_n           = rts_q;
  assign radio_fifo_wr   = fwr_q;
  assign radio_fifo_data = fdata_q;
  assign radio_tx_start  = fstart_q;
  assign radio_rx_enable = rx_en_q;
  assign op_mode         = op_mode_q;
  assign checksum_any    = csum_q;
  assign led_rx          = led_rx_q;
  assign led_tx          = led_tx_q;
  assign ready           = ready_q;

  // Helper: cycles spent starting up, sleep and listen time not counted
  logic [25:0] boot_age_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) boot_age_q <= '0;
    else if (state_q == ST_HOLD || state_q == ST_SLEEP
             || state_q == ST_LISTEN || ready_q) boot_age_q <= '0;
    else boot_age_q <= boot_age_q + 26'h0000001;
  end

  // Checks
  listen_return_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ST_LISTEN && sleep_eff && listen_end |=> state_q == ST_SLEEP)
    else $error("listen window did not end in sleep");
  pin_toggle_a: assert property (@(posedge clk) disable iff (!nrst)
    act_q[FLG_NO_CFG_PIN] && cfg_fall && !tog_brk && state_q == ST_RUN
    |=> $stable(op_mode_q))
    else $error("disabled toggle pin changed the mode");
  req_pin_a: assert property (@(posedge clk) disable iff (!nrst)
    act_q[FLG_NO_DATA_REQ] && !tx_trigger && !txb_full
    && state_q == ST_RUN |=> state_q != ST_TX)
    else $error("disabled send request started a send");
  break_mode_a: assert property (@(posedge clk) disable iff (!nrst)
    act_q[FLG_NO_BREAK] && !tog_pin && uart_break && state_q != ST_HOLD
    |=> $stable(op_mode_q))
    else $error("suppressed break changed the mode");
  sleep_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
    act_q[FLG_NO_SLEEP_PINS] && state_q == ST_RUN |=> state_q != ST_SLEEP)
    else $error("ignored sleep pin put device to sleep");
  csum_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    ##1 checksum_any == $past(act_q[FLG_ANY_CSUM]))
    else $error("checksum bypass does not follow flag");
  cts_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    act_q[FLG_USE_CTS] && cts_n && uart_tx_valid
    |=> uart_tx_valid && $stable(uart_tx_data))
    else $error("byte left while CTS blocked");
  led_off_a: assert property (@(posedge clk) disable iff (!nrst)
    !act_q[FLG_LEDS] |=> !led_rx && !led_tx)
    else $error("activity output without enable");
  boot_rts_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ST_DELAY && cnt_end_delay && restart_n |=> rts_n)
    else $error("RTS not raised after boot delay");
  ready_bound_a: assert property (@(posedge clk) disable iff (!nrst)
    boot_age_q < 26'(READY_MAX_CYC))
    else $error("device not ready in time");
  tx_halt_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == ST_TX || radio_fifo_wr |-> rts_n)
    else $error("RTS low while loading radio FIFO");
  tx_start_a: assert property (@(posedge clk) disable iff (!nrst)
    radio_tx_start |-> radio_fifo_wr)
    else $error("radio start without FIFO byte");
  drop_pkt_a: assert property (@(posedge clk) disable iff (!nrst)
    rx_flush |=> !rx_drain_q && rxb_empty)
    else $error("filtered packet reached UART");

  cov_send_c:   cover property (@(posedge clk) tx_go ##[1:40] radio_tx_start);
  cov_recv_c:   cover property (@(posedge clk) pkt_end && pkt_ok);
  cov_listen_c: cover property (@(posedge clk)
    state_q == ST_LISTEN ##1 state_q == ST_SLEEP);
endmodule // rmhs_device

// File: verification/rmhs_host_model.sv
`timescale 1ns/100ps
module rmhs_host_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic rts_n,
  output logic      uart_tx_ready,
  output logic      cts_n,
  output logic      boot_seen
);
  // Host receive side stalls at random, flow line toggles
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uart_tx_ready <= 1'b0;
      cts_n         <= 1'b1;
    end else begin
      uart_tx_ready <= 1'($urandom % 3 != 0);
      cts_n         <= 1'($urandom % 4 == 0);
    end
  end
  // Host latches the boot high on RTS into boot_seen
  always @(posedge clk or negedge nrst) begin
    if (!nrst) boot_seen <= 1'b0;
    else if (rts_n) boot_seen <= 1'b1;
  end
endmodule // rmhs_host_model

// File: verification/test_radio_module_host_startup_flags.sv
`timescale 1ns/100ps
module test_radio_module_host_startup_flags;
  import rmhs_pkg::*;
  logic          clk = 1'b0, nrst = 1'b0, restart_n = 1'b1;
  logic [AW-1:0] reg_addr = '0;
  logic [RW-1:0] reg_wdata = '0, reg_rdata;
  logic          reg_wr = 0, reg_rd = 0, uart_rx_valid = 0, uart_break = 0;
  logic [DW-1:0] uart_rx_data = '0, radio_rx_data = '0;
  logic          config_pin_n = 1, tx_trigger = 0, radio_rx_valid = 0;
  logic          radio_rx_last = 0, radio_fifo_ready = 0, data_req_n = 1;
  logic          sleep_pin = 0, radio_off_pin = 0, wor_wake = 0;
  logic [DW-1:0] uart_tx_data, radio_fifo_data;
  logic          uart_tx_valid, uart_tx_ready, cts_n, rts_n, radio_fifo_wr;
  logic          radio_tx_start, op_mode, ready, boot_seen;
  logic          rx_en, checksum_any, led_rx, led_tx;
  int            error_cnt = 0, samples_checked = 0, use_cts = 0, first = 0;
  logic [DW-1:0] exp_r[$], exp_u[$];
  logic          exp_mode = 0;
  // Shortened counts keep the boot sequence to a few cycles
  rmhs_device #(.BOOT_DELAY_CYCLES(4), .CAL_CYCLES(8), .READY_CYCLES(8),
    .MS_CYCLES(4)) dut (.clk, .nrst, .restart_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .uart_rx_valid, .uart_rx_data,
    .uart_break, .uart_tx_valid, .uart_tx_data, .uart_tx_ready, .cts_n,
    .rts_n, .config_pin_n, .data_req_n, .sleep_pin, .radio_off_pin,
    .wor_wake, .tx_trigger, .radio_fifo_wr, .radio_fifo_data,
    .radio_fifo_ready, .radio_tx_start, .radio_rx_valid, .radio_rx_data,
    .radio_rx_last, .radio_rx_enable(rx_en), .op_mode, .checksum_any,
    .led_rx, .led_tx, .ready);
  rmhs_host_model host (.clk, .nrst, .rts_n, .uart_tx_ready, .cts_n,
    .boot_seen);
  always #10 clk = ~clk;
  // Transceiver FIFO room comes and goes
  always @(posedge clk) radio_fifo_ready <= 1'($urandom % 2);
  task automatic chk(input logic [RW-1:0] g, input logic [RW-1:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [RW-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [RW-1:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata, e);
  endtask
  task automatic wait_rdy();
    for (int n = 0; n < 300 && ready !== 1'b1; n++) @(posedge clk);
    chk(16'(ready), 16'h0001);
  endtask
  task automatic wait_q(input int r);
    for (int n = 0; n < 400 && (r ? exp_r.size() : exp_u.size()) != 0; n++)
      @(posedge clk);
    chk(16'(r ? exp_r.size() : exp_u.size()), 16'h0000);
  endtask
  // Back-to-back host bytes, then the send request pin; with pin 0 the
  // pin must be ignored, so a send trigger follows after a pause
  task automatic send(input int n, input int pin);
    logic [DW-1:0] b;
    for (int i = 0; i < n; i++) begin
      b = DW'($urandom);
      exp_r.push_back(b);
      @(posedge clk);
      uart_rx_valid <= 1'b1;
      uart_rx_data <= b;
    end
    @(posedge clk);
    uart_rx_valid <= 1'b0;
    data_req_n <= 1'b0;
    first = 1;
    @(posedge clk);
    data_req_n <= 1'b1;
    if (pin == 0) begin
      repeat (10) @(posedge clk);
      chk(16'(exp_r.size()), 16'(n));
      tx_trigger <= 1'b1;
      @(posedge clk);
      tx_trigger <= 1'b0;
    end
    wait_q(1);
  endtask
  // Two-byte radio packet; model decides if it reaches the host
  task automatic pkt(input logic [DW-1:0] a, input int sniff);
    logic [DW-1:0] b;
    b = DW'($urandom);
    if (a == OWN_ADDR_RESET || a == BCAST_ADDR || sniff != 0) begin
      exp_u.push_back(a);
      exp_u.push_back(b);
    end
    @(posedge clk);
    radio_rx_valid <= 1'b1;
    radio_rx_data <= a;
    @(posedge clk);
    radio_rx_data <= b;
    radio_rx_last <= 1'b1;
    @(posedge clk);
    radio_rx_valid <= 1'b0;
    radio_rx_last <= 1'b0;
    chk(16'(led_rx), 16'(use_cts));
    wait_q(0);
  endtask
  task automatic toggle(input int pin, input int off);
    @(posedge clk);
    if (pin != 0) config_pin_n <= 1'b0;
    else uart_break <= 1'b1;
    @(posedge clk);
    config_pin_n <= 1'b1;
    uart_break <= 1'b0;
    repeat (3) @(posedge clk);
    if (off == 0) exp_mode = ~exp_mode;
    chk(16'(op_mode), 16'(exp_mode));
  endtask
  // Compare every byte leaving toward radio and host with the model
  always @(posedge clk) begin
    if (radio_fifo_wr === 1'b1) begin
      chk(16'(radio_tx_start), 16'(first));
      chk(16'(led_tx), 16'(use_cts));
      chk(16'(rts_n), 16'h0001);
      chk(16'(radio_fifo_data), 16'(exp_r.pop_front()));
      first = 0;
    end
    if (uart_tx_valid === 1'b1 && uart_tx_ready === 1'b1 &&
        (use_cts == 0 || cts_n === 1'b0))
      chk(16'(uart_tx_data), 16'(exp_u.pop_front()));
  end
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(33));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    wait_rdy();
    chk(16'(boot_seen), 16'h0001);
    rd(REG_FLAGS, FLAGS_RESET);
    rd(REG_MODE, 16'(MODE_RESET));
    rd(REG_LISTEN, 16'(LISTEN_RESET));
    rd(REG_OWN_ADDR, 16'(OWN_ADDR_RESET));
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    send(3, 1);
    pkt(OWN_ADDR_RESET, 0);
    pkt(BCAST_ADDR, 0);
    pkt(8'h22, 0);
    toggle(1, 0);
    toggle(0, 0);
    // Sleep, one timed listen window, then wake
    sleep_pin <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'({rts_n, ready}), 16'h0002);
    wor_wake <= 1'b1;
    @(posedge clk);
    wor_wake <= 1'b0;
    repeat (4) @(posedge clk);
    chk(16'({rts_n, rx_en}), 16'h0003);
    repeat (60) @(posedge clk);
    chk(16'({rts_n, rx_en}), 16'h0002);
    sleep_pin <= 1'b0;
    wait_rdy();
    chk(16'({rts_n, checksum_any}), 16'h0000);
    wr(REG_FLAGS, 16'hFFFF);
    rd(REG_FLAGS, FLAGS_WRITABLE);
    wr(REG_FLAGS, 16'h03AF);
    rd(REG_ACTIVE, 16'h0000);
    restart_n <= 1'b0;
    repeat (3) @(posedge clk);
    restart_n <= 1'b1;
    wait_rdy();
    rd(REG_ACTIVE, 16'h03AF);
    use_cts = 1;
    // Sleep and radio off pin levels are ignored now
    sleep_pin <= 1'b1;
    radio_off_pin <= 1'b1;
    repeat (4) @(posedge clk);
    chk(16'({ready, rx_en, checksum_any}), 16'h0007);
    sleep_pin <= 1'b0;
    radio_off_pin <= 1'b0;
    pkt(8'h22, 1);
    toggle(1, 1);
    toggle(0, 1);
    send(4, 0);
    report_and_stop();
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule // test_radio_module_host_startup_flags
